// ### inc/pimls_params.svh
/*
  Offsets, field positions and reset values of the event mask and link
  status bank. Assumes inclusion by bare name from the design files.
*/
`ifndef PIMLS_PARAMS_SVH
`define PIMLS_PARAMS_SVH
// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define PIMLS_IDX_IRQ_STAT 6'h15
`define PIMLS_IDX_IRQ_MASK 6'h16
`define PIMLS_IDX_COMM_STAT 6'h17
`define PIMLS_IDX_LINK_CTRL 6'h20
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PIMLS_MASK_RST 16'h8000
`define PIMLS_LINK_CTRL_RST 1'b1
`define PIMLS_TX_MODE_RST 2'h0
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PIMLS_BIT_LINK_UP 15
`define PIMLS_BIT_TX_MODE_HI 14
`define PIMLS_BIT_TX_MODE_LO 13
`define PIMLS_BIT_LOC_OK 12
`define PIMLS_BIT_REM_OK 11
`define PIMLS_BIT_DESCR 10
`define PIMLS_BIT_SSD 9
`define PIMLS_BIT_LINK_CTRL 15
`endif

// ### inc/pimls_pkg.sv
/*
  Types shared by the mask and status bank modules.
  Assumes nothing of its surroundings.
*/
package pimls_pkg;
  typedef logic [15:0] pimls_word_t;
  typedef logic [5:0] pimls_idx_t;
  typedef enum logic [1:0] {
    PIMLS_TX_OFF = 2'h0,
    PIMLS_TX_SEND_N = 2'h1,
    PIMLS_TX_SEND_I = 2'h2,
    PIMLS_TX_SEND_Z = 2'h3
  } pimls_tx_mode_t;
  typedef enum logic {PIMLS_APB_IDLE, PIMLS_APB_RESP} pimls_apb_state_t;
endpackage

// ### inc/pimls_reg_if.sv
/*
  Register access carrier between the APB slave and the register bank.
  Assumes both ends run on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
interface pimls_reg_if;
  logic acc;
  logic wr;
  logic [1:0] be;
  pimls_pkg::pimls_idx_t idx;
  pimls_pkg::pimls_word_t wdata;
  pimls_pkg::pimls_word_t rdata;
  logic hit;
  modport bus (output acc, output wr, output be, output idx, output wdata,
               input rdata, input hit);
  modport regs (input acc, input wr, input be, input idx, input wdata,
                output rdata, output hit);
endinterface
`default_nettype wire

// ### rtl/pimls_apb_slave.sv
/*
  APB slave front end: decodes one word per register, issues a single
  access strobe and answers with one wait state.
  Assumes an APB master on pclk that holds its request until pready.
*/
`timescale 1ns/1ps
`default_nettype none
module pimls_apb_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  pimls_reg_if.bus rif
);
  pimls_pkg::pimls_apb_state_t state;
  logic addr_ok;
  logic first;

  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:8] == 4'h0);
  assign first = psel && penable && (state == pimls_pkg::PIMLS_APB_IDLE);
  // Side effects land with the data capture, so no event slips between
  assign rif.acc = first && addr_ok;
  assign rif.wr = pwrite;
  assign rif.be = pstrb[1:0];
  assign rif.idx = paddr[7:2];
  assign rif.wdata = pwdata[15:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= pimls_pkg::PIMLS_APB_IDLE;
      pready <= 1'b0;
    end else begin
      unique case (state)
        pimls_pkg::PIMLS_APB_IDLE: begin
          pready <= first;
          if (first) begin
            state <= pimls_pkg::PIMLS_APB_RESP;
          end
        end
        pimls_pkg::PIMLS_APB_RESP: begin
          pready <= 1'b0;
          state <= pimls_pkg::PIMLS_APB_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (first) begin
      prdata <= (pwrite || !(addr_ok && rif.hit)) ? 32'h0
                : {16'h0, rif.rdata};
      pslverr <= !(addr_ok && rif.hit);
    end
  end
endmodule // pimls_apb_slave
`default_nettype wire

// ### rtl/pimls_latch_bank.sv
/*
  Bank of latch flags re-armed from the live level on read, each latching high or low.
  Assumes rearm is a one-cycle pulse taken with the read data.
*/
`timescale 1ns/1ps
`default_nettype none
module pimls_latch_bank #(
  parameter int W = 16,
  parameter logic [W-1:0] LATCH_LOW = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] live,
  input wire logic rearm,
  input wire logic hold_def,
  output logic [W-1:0] flag
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flag[i] <= 1'b0;
        end else if (hold_def) begin
          flag[i] <= 1'b0;
        end else if (rearm) begin
          // Re-arm from the live level: an event in this cycle survives
          flag[i] <= live[i];
        end else if (LATCH_LOW[i]) begin
          flag[i] <= flag[i] & live[i];
        end else begin
          flag[i] <= flag[i] | live[i];
        end
      end
    end
  endgenerate
endmodule // pimls_latch_bank
`default_nettype wire

// ### rtl/pimls_top.sv
/*
  Event interrupt mask and link communication status bank of a
  single-pair PHY, reached over APB.
  Assumes event and status inputs synchronous to pclk, events as pulses.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pimls_params.svh"
module pimls_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [15:0] event_in,
  input wire logic link_up_in,
  input wire logic [1:0] tx_mode_in,
  input wire logic local_rx_ok_in,
  input wire logic remote_rx_ok_in,
  input wire logic descr_lock_in,
  input wire logic ssd_fault_in,
  output logic link_control,
  output logic irq
);
  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic idx_is(input pimls_pkg::pimls_idx_t a,
                                  input pimls_pkg::pimls_idx_t b);
    idx_is = (a == b);
  endfunction

  function automatic logic idx_mapped(input pimls_pkg::pimls_idx_t a);
    idx_mapped = idx_is(a, `PIMLS_IDX_IRQ_STAT) ||
                 idx_is(a, `PIMLS_IDX_IRQ_MASK) ||
                 idx_is(a, `PIMLS_IDX_COMM_STAT) ||
                 idx_is(a, `PIMLS_IDX_LINK_CTRL);
  endfunction

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  pimls_reg_if rif ();

  pimls_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .rif(rif.bus)
  );

  // ----------------------------------------------------------------
  // Access strobes
  // ----------------------------------------------------------------
  logic mask_wr;
  logic ctrl_wr;
  logic stat_rd;
  logic comm_rd;

  assign mask_wr = rif.acc && rif.wr && idx_is(rif.idx, `PIMLS_IDX_IRQ_MASK);
  assign ctrl_wr = rif.acc && rif.wr && idx_is(rif.idx, `PIMLS_IDX_LINK_CTRL);
  // Only reads re-arm; a write to a status word is dropped silently
  assign stat_rd = rif.acc && !rif.wr &&
                   idx_is(rif.idx, `PIMLS_IDX_IRQ_STAT);
  assign comm_rd = rif.acc && !rif.wr &&
                   idx_is(rif.idx, `PIMLS_IDX_COMM_STAT);

  // ----------------------------------------------------------------
  // Event mask register
  // ----------------------------------------------------------------
  pimls_pkg::pimls_word_t irq_mask;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= `PIMLS_MASK_RST;
    end else if (mask_wr) begin
      if (rif.be[0]) begin
        irq_mask[7:0] <= rif.wdata[7:0];
      end
      if (rif.be[1]) begin
        irq_mask[15:8] <= rif.wdata[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Enable fields
  // ----------------------------------------------------------------
  logic power_on_irq_enable;
  logic wake_detect_irq_enable;
  logic wake_request_irq_enable;
  logic low_power_code_irq_enable;
  logic init_failure_irq_enable;
  logic link_drop_irq_enable;
  logic link_rise_irq_enable;
  logic bad_symbol_irq_enable;
  logic train_failure_irq_enable;
  logic low_noise_margin_irq_enable;
  logic mgmt_ctrl_err_irq_enable;
  logic tx_gate_stuck_irq_enable;
  logic undervolt_irq_enable;
  logic undervolt_recover_irq_enable;
  logic overtemp_irq_enable;
  logic sleep_timeout_irq_enable;

  assign power_on_irq_enable = irq_mask[15];
  assign wake_detect_irq_enable = irq_mask[14];
  assign wake_request_irq_enable = irq_mask[13];
  assign low_power_code_irq_enable = irq_mask[12];
  assign init_failure_irq_enable = irq_mask[11];
  assign link_drop_irq_enable = irq_mask[10];
  assign link_rise_irq_enable = irq_mask[9];
  assign bad_symbol_irq_enable = irq_mask[8];
  assign train_failure_irq_enable = irq_mask[7];
  assign low_noise_margin_irq_enable = irq_mask[6];
  assign mgmt_ctrl_err_irq_enable = irq_mask[5];
  assign tx_gate_stuck_irq_enable = irq_mask[4];
  assign undervolt_irq_enable = irq_mask[3];
  assign undervolt_recover_irq_enable = irq_mask[2];
  assign overtemp_irq_enable = irq_mask[1];
  assign sleep_timeout_irq_enable = irq_mask[0];

  // ----------------------------------------------------------------
  // Link control register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_control <= `PIMLS_LINK_CTRL_RST;
    end else if (ctrl_wr && rif.be[1]) begin
      link_control <= rif.wdata[`PIMLS_BIT_LINK_CTRL];
    end
  end

  // ----------------------------------------------------------------
  // Link control gating
  // ----------------------------------------------------------------
  logic link_off;

  assign link_off = !link_control;

  // ----------------------------------------------------------------
  // Event flags, one per mask bit
  // ----------------------------------------------------------------
  pimls_pkg::pimls_word_t irq_stat;

  pimls_latch_bank #(
    .W(16),
    .LATCH_LOW(16'h0000)
  ) u_events (
    .pclk(pclk),
    .presetn(presetn),
    .live(event_in),
    .rearm(stat_rd),
    .hold_def(1'b0),
    .flag(irq_stat)
  );

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  pimls_pkg::pimls_word_t enables;

  assign enables = {
    power_on_irq_enable,
    wake_detect_irq_enable,
    wake_request_irq_enable,
    low_power_code_irq_enable,
    init_failure_irq_enable,
    link_drop_irq_enable,
    link_rise_irq_enable,
    bad_symbol_irq_enable,
    train_failure_irq_enable,
    low_noise_margin_irq_enable,
    mgmt_ctrl_err_irq_enable,
    tx_gate_stuck_irq_enable,
    undervolt_irq_enable,
    undervolt_recover_irq_enable,
    overtemp_irq_enable,
    sleep_timeout_irq_enable
  };

  // ----------------------------------------------------------------
  // Interrupt pending, one bit per event
  // ----------------------------------------------------------------
  wire logic [15:0] pending;
  logic next_irq;
  genvar gi;

  generate
    for (gi = 0; gi < 16; gi++) begin : g_pending
      assign pending[gi] = irq_stat[gi] && enables[gi];
    end
  endgenerate

  assign next_irq = |pending;

  // ----------------------------------------------------------------
  // Interrupt line
  // ----------------------------------------------------------------
  // Registered, so it trails a flag or mask change by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Live link status
  // ----------------------------------------------------------------
  logic link_up;
  pimls_pkg::pimls_tx_mode_t tx_mode;
  logic descrambler_lock;
  logic next_link_up;
  logic next_descrambler_lock;

  assign next_link_up = link_control && link_up_in;
  assign next_descrambler_lock = link_control && descr_lock_in;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_up <= 1'b0;
    end else begin
      link_up <= next_link_up;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_mode <= pimls_pkg::PIMLS_TX_OFF;
    end else if (link_off) begin
      tx_mode <= pimls_pkg::PIMLS_TX_OFF;
    end else begin
      tx_mode <= pimls_pkg::pimls_tx_mode_t'(tx_mode_in);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      descrambler_lock <= 1'b0;
    end else begin
      descrambler_lock <= next_descrambler_lock;
    end
  end

  // ----------------------------------------------------------------
  // Latched link status
  // ----------------------------------------------------------------
  logic [2:0] comm_flags;
  logic local_receiver_ok;
  logic remote_receiver_ok;
  logic stream_start_delim_fault;
  logic [2:0] comm_live;

  // Two latch-low bits above one latch-high bit
  assign comm_live = {local_rx_ok_in, remote_rx_ok_in, ssd_fault_in};

  pimls_latch_bank #(
    .W(3),
    .LATCH_LOW(3'h6)
  ) u_comm (
    .pclk(pclk),
    .presetn(presetn),
    .live(comm_live),
    .rearm(comm_rd),
    .hold_def(link_off),
    .flag(comm_flags)
  );

  assign local_receiver_ok = comm_flags[2];
  assign remote_receiver_ok = comm_flags[1];
  assign stream_start_delim_fault = comm_flags[0];

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  pimls_pkg::pimls_word_t comm_word;

  always_comb begin
    comm_word = 16'h0000;
    comm_word[`PIMLS_BIT_LINK_UP] = link_up;
    comm_word[`PIMLS_BIT_TX_MODE_HI:`PIMLS_BIT_TX_MODE_LO] = tx_mode;
    comm_word[`PIMLS_BIT_LOC_OK] = local_receiver_ok;
    comm_word[`PIMLS_BIT_REM_OK] = remote_receiver_ok;
    comm_word[`PIMLS_BIT_DESCR] = descrambler_lock;
    comm_word[`PIMLS_BIT_SSD] = stream_start_delim_fault;
  end

  pimls_pkg::pimls_word_t ctrl_word;

  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[`PIMLS_BIT_LINK_CTRL] = link_control;
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rif.hit = idx_mapped(rif.idx);
    rif.rdata = 16'h0000;
    if (idx_is(rif.idx, `PIMLS_IDX_IRQ_STAT)) begin
      rif.rdata = irq_stat;
    end else if (idx_is(rif.idx, `PIMLS_IDX_IRQ_MASK)) begin
      rif.rdata = irq_mask;
    end else if (idx_is(rif.idx, `PIMLS_IDX_COMM_STAT)) begin
      rif.rdata = comm_word;
    end else if (idx_is(rif.idx, `PIMLS_IDX_LINK_CTRL)) begin
      rif.rdata = ctrl_word;
    end
  end
endmodule // pimls_top
`default_nettype wire

// ### dv/pimls_top_properties.sv
/*
  Port-level checker for the event mask and link status bank.
  Assumes it is bound to pimls_top, one clock domain on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pimls_params.svh"
module pimls_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [15:0] event_in,
  input wire logic link_control,
  input wire logic irq
);
  localparam logic [11:0] A_MASK = {4'h0, `PIMLS_IDX_IRQ_MASK, 2'h0};
  localparam logic [11:0] A_COMM = {4'h0, `PIMLS_IDX_COMM_STAT, 2'h0};
  logic xfer;
  assign xfer = psel && penable;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  property p_one_wait;
    xfer && !pready |=> pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready late");
  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready long");
  property p_rdy_cause;
    pready |-> xfer && $past(xfer);
  endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("stray pready");
  property p_err_align;
    pready && paddr[1:0] != 2'h0 |-> pslverr;
  endproperty
  a_err_align: assert property (p_err_align) else $error("no error");
  property p_mask_ok;
    pready && paddr == A_MASK |-> !pslverr;
  endproperty
  a_mask_ok: assert property (p_mask_ok) else $error("mask error");
  property p_wr_zero;
    pready && pwrite |-> prdata == 32'h0;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write data");
  property p_hi_zero;
    pready |-> prdata[31:16] == 16'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper half");
  // Read data may only move on a taken transfer
  property p_hold;
    $changed(prdata) |-> $past(xfer);
  endproperty
  a_hold: assert property (p_hold) else $error("prdata moved");
  // ----------------------------------------
  // Status and interrupt
  // ----------------------------------------
  property p_lc_off;
    pready && !pwrite && !pslverr && paddr == A_COMM && !link_control
      |-> prdata[15:9] == 7'h0;
  endproperty
  a_lc_off: assert property (p_lc_off) else $error("status shown");
  property p_irq_rise;
    $rose(irq) |-> $past(|event_in, 2) || $past(xfer && pwrite, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rise");
  property p_irq_fall;
    $fell(irq) |-> $past(xfer, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fall");
  c_write: cover property (pready && pwrite && !pslverr);
  c_comm: cover property (pready && !pwrite && paddr == A_COMM);
  c_err: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
endmodule // pimls_props
bind pimls_top pimls_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .event_in(event_in), .link_control(link_control),
  .irq(irq)
);
`default_nettype wire

// ### dv/phy_irq_mask_and_link_status_tb_top.sv
/*
  Self-checking bench for the event mask and link status bank.
  Assumes the package, interface, design and checker compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pimls_params.svh"
module phy_irq_mask_and_link_status_tb_top;
  localparam logic [11:0] A_STAT = {4'h0, `PIMLS_IDX_IRQ_STAT, 2'h0};
  localparam logic [11:0] A_MASK = {4'h0, `PIMLS_IDX_IRQ_MASK, 2'h0};
  localparam logic [11:0] A_COMM = {4'h0, `PIMLS_IDX_COMM_STAT, 2'h0};
  localparam logic [11:0] A_LC = {4'h0, `PIMLS_IDX_LINK_CTRL, 2'h0};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [15:0] event_in;
  logic [1:0] tx_mode_in;
  logic link_up_in, local_rx_ok_in, remote_rx_ok_in;
  logic descr_lock_in, ssd_fault_in, link_control, irq, er;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  always #4 pclk = ~pclk;
  pimls_top uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .event_in(event_in), .link_up_in(link_up_in),
    .tx_mode_in(tx_mode_in), .local_rx_ok_in(local_rx_ok_in),
    .remote_rx_ok_in(remote_rx_ok_in), .descr_lock_in(descr_lock_in),
    .ssd_fault_in(ssd_fault_in), .link_control(link_control), .irq(irq)
  );
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request stands until pready is sampled high at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [15:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a,
                       input logic [15:0] e);
    xfer(1'b0, a, 16'h0, 4'h0);
    chk(nm, {16'h0, e}, rd);
    chk("pslverr", 32'h0, {31'h0, er});
  endtask
  task automatic pulse(input logic [15:0] ev);
    @(posedge pclk);
    event_in <= ev;
    @(posedge pclk);
    event_in <= 16'h0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge pclk);
  endtask
  function automatic logic [15:0] comm(logic lu, logic [1:0] tm,
                                       logic lo, ro, dl, sf);
    return {lu, tm, lo, ro, dl, sf, 9'h0};
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdchk("mask", A_MASK, 16'h8000);
    rdchk("comm", A_COMM, 16'h0);
    chk("link_control", 32'h1, {31'h0, link_control});
    chk("irq", 32'h0, {31'h0, irq});
    $display("reset test done");
  endtask
  task automatic t_mask;
    logic [15:0] v[3];
    v = '{16'hffff, 16'h0000, 16'h5a5a};
    foreach (v[i]) begin
      xfer(1'b1, A_MASK, v[i], 4'h3);
      rdchk("mask", A_MASK, v[i]);
    end
    xfer(1'b1, A_MASK, 16'hffff, 4'h1);
    rdchk("mask lane", A_MASK, 16'h5aff);
    xfer(1'b1, A_COMM, 16'hffff, 4'h3);
    rdchk("comm ro", A_COMM, 16'h0);
    $display("mask test done");
  endtask
  task automatic t_status;
    @(posedge pclk);
    link_up_in <= 1'b1;
    descr_lock_in <= 1'b1;
    local_rx_ok_in <= 1'b1;
    remote_rx_ok_in <= 1'b1;
    // Receiver bits stay low until the first read after they came good
    rdchk("comm", A_COMM, comm(1, 0, 0, 0, 1, 0));
    for (int m = 0; m < 4; m++) begin
      @(posedge pclk);
      tx_mode_in <= m[1:0];
      rdchk("tx mode", A_COMM, comm(1, m[1:0], 1, 1, 1, 0));
    end
    @(posedge pclk);
    local_rx_ok_in <= 1'b0;
    @(posedge pclk);
    local_rx_ok_in <= 1'b1;
    rdchk("loc ll", A_COMM, comm(1, 3, 0, 1, 1, 0));
    rdchk("loc rearm", A_COMM, comm(1, 3, 1, 1, 1, 0));
    @(posedge pclk);
    remote_rx_ok_in <= 1'b0;
    @(posedge pclk);
    remote_rx_ok_in <= 1'b1;
    rdchk("rem ll", A_COMM, comm(1, 3, 1, 0, 1, 0));
    rdchk("rem rearm", A_COMM, comm(1, 3, 1, 1, 1, 0));
    @(posedge pclk);
    ssd_fault_in <= 1'b1;
    @(posedge pclk);
    ssd_fault_in <= 1'b0;
    rdchk("ssd lh", A_COMM, comm(1, 3, 1, 1, 1, 1));
    rdchk("ssd rearm", A_COMM, comm(1, 3, 1, 1, 1, 0));
    @(posedge pclk);
    link_up_in <= 1'b0;
    descr_lock_in <= 1'b0;
    rdchk("link lost", A_COMM, comm(0, 3, 1, 1, 0, 0));
    @(posedge pclk);
    link_up_in <= 1'b1;
    descr_lock_in <= 1'b1;
    $display("status test done");
  endtask
  task automatic t_lc;
    xfer(1'b1, A_LC, 16'h0, 4'h3);
    chk("link_control", 32'h0, {31'h0, link_control});
    rdchk("lc reg", A_LC, 16'h0);
    rdchk("comm off", A_COMM, 16'h0);
    xfer(1'b1, A_LC, 16'h8000, 4'h3);
    chk("link_control", 32'h1, {31'h0, link_control});
    xfer(1'b0, A_COMM, 16'h0, 4'h0);
    chk("comm on", 32'hf, {28'h0, rd[15:13], rd[10]});
    $display("link control test done");
  endtask
  task automatic t_irq;
    logic [15:0] b;
    xfer(1'b1, A_MASK, 16'h0, 4'h3);
    pulse(16'h4000);
    wt(3);
    chk("irq masked", 32'h0, {31'h0, irq});
    // Flag latched while masked must fire once enabled
    xfer(1'b1, A_MASK, 16'h4000, 4'h3);
    wt(2);
    chk("irq late", 32'h1, {31'h0, irq});
    rdchk("stat", A_STAT, 16'h4000);
    wt(2);
    chk("irq clr", 32'h0, {31'h0, irq});
    for (int i = 0; i < 16; i++) begin
      b = 16'h1 << i;
      xfer(1'b1, A_MASK, b, 4'h3);
      pulse(b);
      wt(3);
      chk("irq", 32'h1, {31'h0, irq});
      rdchk("stat", A_STAT, b);
      wt(2);
      chk("irq clr", 32'h0, {31'h0, irq});
    end
    $display("interrupt test done");
  endtask
  task automatic t_err;
    xfer(1'b0, 12'h0fc, 16'h0, 4'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    xfer(1'b1, 12'h0fc, 16'hffff, 4'h3);
    chk("unmapped wr", 32'h1, {31'h0, er});
    xfer(1'b1, A_MASK + 12'h1, 16'h0, 4'h3);
    chk("misaligned", 32'h1, {31'h0, er});
    rdchk("mask kept", A_MASK, 16'h8000);
    $display("error test done");
  endtask
  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Run is a few hundred cycles; the ceiling leaves ample margin
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      conclude;
    end
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, pstrb, paddr, pwdata} = '0;
    event_in = 16'h0;
    tx_mode_in = 2'h0;
    {link_up_in, local_rx_ok_in, remote_rx_ok_in} = 3'h0;
    {descr_lock_in, ssd_fault_in} = 2'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_mask;
    t_status;
    t_lc;
    t_irq;
    t_err;
    conclude;
  end
endmodule // phy_irq_mask_and_link_status_tb_top
`default_nettype wire
